/* File: brt_pkg.sv */
`default_nettype none
package brt_pkg;

  localparam int CELLS    = 36;
  localparam int HALF     = 18;
  localparam int CTL_W    = 8;
  localparam int OP_W     = 3;
  localparam int SYNC_W   = 42;

  // Opcode encodings
  localparam logic [1:0] OP_LOW_TOGGLE = 2'h0;
  localparam logic [1:0] OP_LOW_GEN36  = 2'h1;
  localparam logic [1:0] OP_LOW_PSA36  = 2'h2;
  localparam logic [2:0] OP_COMB_GEN   = 3'h3;
  localparam logic [2:0] OP_COMB_CNT   = 3'h7;

  typedef enum {
    BRT_SAMPLE_AND_TOGGLE,
    BRT_PATTERN_GENERATION,
    BRT_SIGNATURE_COMPRESSION,
    BRT_COMBINED_COMPRESS_GENERATE,
    BRT_COMBINED_COMPRESS_COUNT
  } brt_mode_e;

  // Feedback taps: x^36+x^25+1 and x^18+x^11+1
  localparam int TAP36_HI = 35;
  localparam int TAP36_LO = 24;
  localparam int TAP18_HI = 17;
  localparam int TAP18_LO = 10;

  // Direction enables inside the control cells (chain bits 43..40)
  localparam int B1A = 7;
  localparam int B1B = 6;
  localparam int B2A = 5;
  localparam int B2B = 4;

  // Register map
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_SHIFT_LO  = 8'h08;
  localparam logic [7:0] REG_SHIFT_HI  = 8'h0c;
  localparam logic [7:0] REG_CTLCELL   = 8'h10;
  localparam logic [7:0] REG_SHADOW_LO = 8'h14;
  localparam logic [7:0] REG_SHADOW_HI = 8'h18;

  localparam int ST_RUNNING = 0;
  localparam int ST_DIR_OK  = 1;
  localparam int ST_A_TO_B  = 2;
  localparam int ST_BYPASS  = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

/* File: brt_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module brt_sync
  import brt_pkg::*;
#(
  parameter int WIDTH = SYNC_W
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        meta_nxt[g] = async_in[g];
        sync_nxt[g] = meta_r[g];
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

/* File: brt_engine.sv */
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module brt_engine
  import brt_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              tck,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe,
  input  wire logic              tap_run_test_idle,
  input  wire logic              run_selected_test,
  input  wire logic              tap_capture_dr,
  input  wire logic              tap_shift_dr,
  input  wire logic [HALF-1:0]   a_pin_in,
  output logic      [HALF-1:0]   a_pin_out,
  output logic      [1:0]        a_pin_oe,
  input  wire logic [HALF-1:0]   b_pin_in,
  output logic      [HALF-1:0]   b_pin_out,
  output logic      [1:0]        b_pin_oe
);

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_known(input logic [ADDR_W-1:0] addr);
    logic hit;
    if (addr == REG_CTRL) begin
      hit = 1'b1;
    end else if (addr == REG_STATUS || addr == REG_SHIFT_LO || addr == REG_SHIFT_HI) begin
      hit = 1'b1;
    end else if (addr == REG_CTLCELL || addr == REG_SHADOW_LO || addr == REG_SHADOW_HI) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  function automatic logic [CELLS-1:0] lfsr36(input logic [CELLS-1:0] v);
    return {v[CELLS-2:0], v[TAP36_HI] ^ v[TAP36_LO]};
  endfunction

  function automatic logic [HALF-1:0] lfsr18(input logic [HALF-1:0] v);
    return {v[HALF-2:0], v[TAP18_HI] ^ v[TAP18_LO]};
  endfunction

  // Pin and TAP inputs, synchronised
  logic [SYNC_W-1:0] sync_s;
  logic              tck_s;
  logic              tdi_s;
  logic              idle_s;
  logic              runsel_s;
  logic              cap_s;
  logic              shdr_s;
  logic [HALF-1:0]   a_in_s;
  logic [HALF-1:0]   b_in_s;

  brt_sync #(.WIDTH(SYNC_W)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({tck, tdi, tap_run_test_idle, run_selected_test,
                tap_capture_dr, tap_shift_dr, a_pin_in, b_pin_in}),
    .sync_out (sync_s)
  );

  assign {tck_s, tdi_s, idle_s, runsel_s, cap_s, shdr_s, a_in_s, b_in_s} = sync_s;

  // AXI write side
  logic              awready_r, awready_nxt;
  logic              wready_r, wready_nxt;
  logic              aw_have_r, aw_have_nxt;
  logic              w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              wr_fire;

  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;

  always_comb begin
    aw_have_nxt = aw_have_r;
    awaddr_nxt  = awaddr_r;
    w_have_nxt  = w_have_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = addr_known(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_nxt = !aw_have_nxt;
    wready_nxt  = !w_have_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // Engine state
  logic [OP_W-1:0]  opcode_r, opcode_nxt;
  logic [CELLS-1:0] shift_r, shift_nxt;
  logic [CELLS-1:0] shadow_r, shadow_nxt;
  logic [CTL_W-1:0] ctl_r, ctl_nxt;
  logic             tck_d_r;
  logic             bypass_r, bypass_nxt;
  logic             tdo_r, tdo_nxt;
  logic             tdo_oe_r, tdo_oe_nxt;
  logic [1:0]       a_oe_r, a_oe_nxt;
  logic [1:0]       b_oe_r, b_oe_nxt;
  logic [HALF-1:0]  a_out_r, b_out_r;

  brt_mode_e        mode;
  logic             tck_rise, tck_fall;
  logic             dir_ok, a_to_b, running;
  logic [HALF-1:0]  in_pins, in_cur, out_cur, in_n, out_n;
  logic [CELLS-1:0] step36;
  logic [31:0]      wr_word;

  assign tck_rise = tck_s && !tck_d_r;
  assign tck_fall = !tck_s && tck_d_r;

  always_comb begin
    case (opcode_r[1:0])
      OP_LOW_TOGGLE: mode = BRT_SAMPLE_AND_TOGGLE;
      OP_LOW_GEN36:  mode = BRT_PATTERN_GENERATION;
      OP_LOW_PSA36:  mode = BRT_SIGNATURE_COMPRESSION;
      default:       mode = (opcode_r == OP_COMB_CNT) ? BRT_COMBINED_COMPRESS_COUNT
                                                      : BRT_COMBINED_COMPRESS_GENERATE;
    endcase
  end

  assign dir_ok  = (ctl_r[B1A] != ctl_r[B1B]) && (ctl_r[B2A] != ctl_r[B2B])
                && (ctl_r[B1A] == ctl_r[B2A]) && (ctl_r[B1B] == ctl_r[B2B]);
  assign a_to_b  = ctl_r[B1B];
  assign running = runsel_s && idle_s && dir_ok;

  always_comb begin
    // Input-mode cells first, output-mode cells second
    in_pins = a_to_b ? a_in_s : b_in_s;
    in_cur  = a_to_b ? shift_r[CELLS-1:HALF] : shift_r[HALF-1:0];
    out_cur = a_to_b ? shift_r[HALF-1:0] : shift_r[CELLS-1:HALF];
    step36  = lfsr36({in_cur, out_cur});
    in_n    = in_cur;
    out_n   = out_cur;
    case (mode)
      BRT_SAMPLE_AND_TOGGLE: begin
        in_n  = in_pins;
        out_n = ~out_cur;
      end
      BRT_PATTERN_GENERATION: begin
        {in_n, out_n} = step36;
      end
      BRT_SIGNATURE_COMPRESSION: begin
        {in_n, out_n} = step36 ^ {in_pins, {HALF{1'b0}}};
      end
      BRT_COMBINED_COMPRESS_GENERATE: begin
        in_n  = lfsr18(in_cur) ^ in_pins;
        out_n = lfsr18(out_cur);
      end
      default: begin
        in_n  = lfsr18(in_cur) ^ in_pins;
        out_n = out_cur + 1'b1;
      end
    endcase
  end

  always_comb begin
    opcode_nxt = opcode_r;
    shift_nxt  = shift_r;
    shadow_nxt = shadow_r;
    ctl_nxt    = ctl_r;
    wr_word    = '0;
    if (wr_fire && !running) begin
      if (awaddr_r == REG_CTRL) begin
        wr_word    = apply_strb({{(32-OP_W){1'b0}}, opcode_r}, wdata_r, wstrb_r);
        opcode_nxt = wr_word[OP_W-1:0];
      end else if (awaddr_r == REG_SHIFT_LO) begin
        wr_word    = apply_strb(shift_r[31:0], wdata_r, wstrb_r);
        shift_nxt[31:0] = wr_word;
      end else if (awaddr_r == REG_SHIFT_HI) begin
        wr_word    = apply_strb({28'h0, shift_r[CELLS-1:32]}, wdata_r, wstrb_r);
        shift_nxt[CELLS-1:32] = wr_word[CELLS-33:0];
      end else if (awaddr_r == REG_CTLCELL) begin
        wr_word    = apply_strb({24'h0, ctl_r}, wdata_r, wstrb_r);
        ctl_nxt    = wr_word[CTL_W-1:0];
      end
    end
    // Control cells are never touched by the engine
    if (running && tck_rise) begin
      shift_nxt = a_to_b ? {in_n, out_n} : {out_n, in_n};
    end
    if (running && tck_fall && mode != BRT_SIGNATURE_COMPRESSION) begin
      if (a_to_b) begin
        shadow_nxt[HALF-1:0] = shift_r[HALF-1:0];
      end else begin
        shadow_nxt[CELLS-1:HALF] = shift_r[CELLS-1:HALF];
      end
    end
  end

  always_comb begin
    bypass_nxt = bypass_r;
    tdo_nxt    = tdo_r;
    tdo_oe_nxt = tdo_oe_r;
    if (runsel_s && tck_rise) begin
      if (cap_s) begin
        bypass_nxt = 1'b0;
      end else if (shdr_s) begin
        bypass_nxt = tdi_s;
      end
    end
    if (tck_fall) begin
      tdo_nxt    = bypass_r;
      tdo_oe_nxt = runsel_s && shdr_s;
    end
    a_oe_nxt = {ctl_r[B2A], ctl_r[B1A]};
    b_oe_nxt = {ctl_r[B2B], ctl_r[B1B]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opcode_r <= '0;
      shift_r  <= '0;
      shadow_r <= '0;
      ctl_r    <= '0;
      tck_d_r  <= 1'b0;
      bypass_r <= 1'b0;
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
      a_oe_r   <= '0;
      b_oe_r   <= '0;
      a_out_r  <= '0;
      b_out_r  <= '0;
    end else begin
      opcode_r <= opcode_nxt;
      shift_r  <= shift_nxt;
      shadow_r <= shadow_nxt;
      ctl_r    <= ctl_nxt;
      tck_d_r  <= tck_s;
      bypass_r <= bypass_nxt;
      tdo_r    <= tdo_nxt;
      tdo_oe_r <= tdo_oe_nxt;
      a_oe_r   <= a_oe_nxt;
      b_oe_r   <= b_oe_nxt;
      a_out_r  <= shadow_nxt[CELLS-1:HALF];
      b_out_r  <= shadow_nxt[HALF-1:0];
    end
  end

  // AXI read side
  logic        arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rd_word;

  always_comb begin
    if (s_axi_araddr == REG_CTRL) begin
      rd_word = {{(32-OP_W){1'b0}}, opcode_r};
    end else if (s_axi_araddr == REG_STATUS) begin
      rd_word = '0;
      rd_word[ST_RUNNING] = running;
      rd_word[ST_DIR_OK]  = dir_ok;
      rd_word[ST_A_TO_B]  = a_to_b;
      rd_word[ST_BYPASS]  = bypass_r;
    end else if (s_axi_araddr == REG_SHIFT_LO) begin
      rd_word = shift_r[31:0];
    end else if (s_axi_araddr == REG_SHIFT_HI) begin
      rd_word = {28'h0, shift_r[CELLS-1:32]};
    end else if (s_axi_araddr == REG_CTLCELL) begin
      rd_word = {24'h0, ctl_r};
    end else if (s_axi_araddr == REG_SHADOW_LO) begin
      rd_word = shadow_r[31:0];
    end else if (s_axi_araddr == REG_SHADOW_HI) begin
      rd_word = {28'h0, shadow_r[CELLS-1:32]};
    end else begin
      rd_word = '0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word;
      rresp_nxt  = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign tdo           = tdo_r;
  assign tdo_oe        = tdo_oe_r;
  assign a_pin_out     = a_out_r;
  assign b_pin_out     = b_out_r;
  assign a_pin_oe      = a_oe_r;
  assign b_pin_oe      = b_oe_r;

endmodule
`default_nettype wire

/* File: brt_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module brt_properties
  import brt_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              tck,
  input wire logic              tap_run_test_idle,
  input wire logic              run_selected_test,
  input wire logic              tdo,
  input wire logic              tdo_oe,
  input wire logic [HALF-1:0]   a_pin_out,
  input wire logic [HALF-1:0]   b_pin_out,
  input wire logic [1:0]        a_pin_oe,
  input wire logic [1:0]        b_pin_oe
);
  logic [3:0] idle_r;
  logic [3:0] idle_nxt;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since a run was last requested, saturating
  always_comb begin
    idle_nxt = idle_r;
    if (run_selected_test && tap_run_test_idle) begin
      idle_nxt = 4'h0;
    end else if (idle_r != 4'hf) begin
      idle_nxt = idle_r + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_r <= 4'hf;
    end else begin
      idle_r <= idle_nxt;
    end
  end

  idle_hold_a: assert property (
    idle_r == 4'hf |-> $stable(a_pin_out) && $stable(b_pin_out))
    else $error("pin outputs moved with no test running");
  pin_at_fall_a: assert property (
    !$stable(a_pin_out) || !$stable(b_pin_out) |-> !tck)
    else $error("pin outputs moved while tck high");
  tdo_at_fall_a: assert property (
    $changed(tdo) || $changed(tdo_oe) |-> !tck)
    else $error("tdo moved while tck high");
  oe_by_write_a: assert property (
    $changed(a_pin_oe) || $changed(b_pin_oe) |-> $past(s_axi_bvalid))
    else $error("output enables moved without a register write");
  rd_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after handshake");
  wr_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after handshake");
  unmapped_rd_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_SHADOW_HI
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind brt_engine brt_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .tck(tck),
  .tap_run_test_idle(tap_run_test_idle), .run_selected_test(run_selected_test),
  .tdo(tdo), .tdo_oe(tdo_oe), .a_pin_out(a_pin_out), .b_pin_out(b_pin_out),
  .a_pin_oe(a_pin_oe), .b_pin_oe(b_pin_oe));
`default_nettype wire

/* File: brt_tap_model.sv */
`timescale 1ns/1ps
`default_nettype none
module brt_tap_model (
  input  wire logic aclk,
  output logic      tck,
  output logic      tdi,
  output logic      tap_run_test_idle,
  output logic      run_selected_test,
  output logic      tap_capture_dr,
  output logic      tap_shift_dr
);
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    tap_run_test_idle = 1'b0;
    run_selected_test = 1'b0;
    tap_capture_dr = 1'b0;
    tap_shift_dr = 1'b0;
  end

  // Levels move with tck low; tdi flips when not shifting
  task automatic state(input logic rst, input logic rti, input logic cap,
                       input logic shf, input logic d);
    @(posedge aclk);
    run_selected_test <= rst;
    tap_run_test_idle <= rti;
    tap_capture_dr    <= cap;
    tap_shift_dr      <= shf;
    tdi               <= shf ? d : ~tdi;
    repeat (4) @(posedge aclk);
  endtask

  // One tck period, five aclk per phase; tck idles low
  task automatic pulse();
    @(posedge aclk);
    tck <= 1'b1;
    repeat (5) @(posedge aclk);
    tck <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import brt_pkg::*;
;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic [HALF-1:0]   a_pin_in = 18'h2a5c3, b_pin_in = 18'h1d0f6, a_pin_out, b_pin_out;
  logic [1:0]        s_axi_bresp, s_axi_rresp, a_pin_oe, b_pin_oe, resp;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              tck, tdi, tdo, tdo_oe, tap_run_test_idle, run_selected_test;
  logic              tap_capture_dr, tap_shift_dr;
  logic [35:0]       shd_q = '0;
  int                error_cnt = 0, n_checks = 0, cyc = 0;

  brt_engine dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tck(tck), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .tap_run_test_idle(tap_run_test_idle),
    .run_selected_test(run_selected_test), .tap_capture_dr(tap_capture_dr),
    .tap_shift_dr(tap_shift_dr), .a_pin_in(a_pin_in), .a_pin_out(a_pin_out),
    .a_pin_oe(a_pin_oe), .b_pin_in(b_pin_in), .b_pin_out(b_pin_out), .b_pin_oe(b_pin_oe));

  brt_tap_model tap (
    .aclk(aclk), .tck(tck), .tdi(tdi), .tap_run_test_idle(tap_run_test_idle),
    .run_selected_test(run_selected_test), .tap_capture_dr(tap_capture_dr),
    .tap_shift_dr(tap_shift_dr));

  initial begin
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Reference step of the shift stages, vector = {input half, output half}
  function automatic logic [35:0] step(input logic [2:0] op, input logic a2b,
                                       input logic [35:0] s, input logic [17:0] p);
    logic [35:0] v;
    logic [17:0] ih;
    logic [17:0] oh;
    v = a2b ? s : {s[17:0], s[35:18]};
    ih = v[35:18];
    oh = v[17:0];
    case (op[1:0])
      2'h0: v = {p, ~oh};
      2'h1: v = {v[34:0], v[TAP36_HI] ^ v[TAP36_LO]};
      2'h2: v = {v[34:0], v[TAP36_HI] ^ v[TAP36_LO]} ^ {p, 18'h0};
      default: begin
        ih = {ih[16:0], ih[TAP18_HI] ^ ih[TAP18_LO]} ^ p;
        oh = op[2] ? oh + 18'h1 : {oh[16:0], oh[TAP18_HI] ^ oh[TAP18_LO]};
        v = {ih, oh};
      end
    endcase
    return a2b ? v : {v[17:0], v[35:18]};
  endfunction

  task automatic run_case(input logic [7:0] ctl, input logic [2:0] op, input logic [35:0] seed,
                          input int n, input logic rti);
    logic [35:0] exp;
    logic [31:0] lo;
    logic [31:0] hi;
    logic        a2b;
    logic        ok;
    a2b = ctl[B1B];
    ok = (ctl[B1A] != ctl[B1B]) && (ctl[B1A] == ctl[B2A]) && (ctl[B1B] == ctl[B2B]);
    exp = seed;
    wr(REG_CTLCELL, {24'h0, ctl});
    wr(REG_SHIFT_LO, seed[31:0]);
    wr(REG_SHIFT_HI, {28'h0, seed[35:32]});
    wr(REG_CTRL, {29'h1fffffff, op});
    tap.state(1'b1, rti, 1'b0, 1'b0, 1'b0);
    rd(REG_STATUS, lo);
    chk(36'(lo), 36'({1'b0, a2b, ok, ok && rti}));
    if (ok && rti) begin
      wr(REG_SHIFT_LO, ~seed[31:0]);
      chk(36'(resp), 36'(RESP_OKAY));
    end
    for (int i = 0; i < n; i++) begin
      tap.pulse();
      if (ok && rti) begin
        exp = step(op, a2b, exp, a2b ? a_pin_in : b_pin_in);
        if (op[1:0] != 2'h2 && a2b) shd_q[17:0] = exp[17:0];
        if (op[1:0] != 2'h2 && !a2b) shd_q[35:18] = exp[35:18];
      end
    end
    tap.state(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(REG_SHIFT_LO, lo);
    rd(REG_SHIFT_HI, hi);
    chk({hi[3:0], lo}, exp);
    chk({a_pin_out, b_pin_out}, shd_q);
    chk(36'({a_pin_oe, b_pin_oe}), 36'({ctl[B2A], ctl[B1A], ctl[B2B], ctl[B1B]}));
    rd(REG_CTLCELL, lo);
    chk(36'(lo), 36'(ctl));
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd(REG_CTRL, d);
    chk(36'(d), 36'h0);
    rd(8'h40, d);
    chk(36'({resp, d}), 36'({RESP_SLVERR, 32'h0}));
    wr(8'h40, 32'h1);
    chk(36'(resp), 36'(RESP_SLVERR));
    s_axi_wstrb <= 4'he;
    wr(REG_CTRL, 32'h7);
    s_axi_wstrb <= 4'hf;
    chk(36'(resp), 36'(RESP_OKAY));
    rd(REG_CTRL, d);
    chk(36'(d), 36'h0);
    $display("test reset done");
  endtask

  task automatic t_ops();
    for (int op = 0; op < 8; op++) begin
      run_case(8'h50, 3'(op), 36'h9_1234_5678, 3, 1'b1);
    end
    $display("test opcodes done");
  endtask

  task automatic t_dir();
    run_case(8'ha0, 3'h1, 36'h5_0f0f_3c3c, 3, 1'b1);
    run_case(8'ha0, 3'h2, 36'h5_0f0f_3c3c, 3, 1'b1);
    run_case(8'ha0, 3'h7, 36'h5_0f0f_3c3c, 3, 1'b1);
    $display("test direction done");
  endtask

  task automatic t_zero();
    a_pin_in <= 18'h0;
    run_case(8'h50, 3'h1, 36'h0, 4, 1'b1);
    run_case(8'h50, 3'h3, 36'h0, 4, 1'b1);
    run_case(8'h50, 3'h7, 36'h0_0003_fffe, 3, 1'b1);
    a_pin_in <= 18'h35a91;
    $display("test zero seed and count wrap done");
  endtask

  task automatic t_gate();
    run_case(8'h50, 3'h1, 36'h7_7777_0001, 3, 1'b0);
    run_case(8'hc0, 3'h1, 36'h7_7777_0001, 3, 1'b1);
    run_case(8'h90, 3'h3, 36'h7_7777_0001, 3, 1'b1);
    $display("test gating done");
  endtask

  task automatic t_bypass();
    tap.state(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    tap.pulse();
    chk(36'({tdo_oe, tdo}), 36'h3);
    tap.state(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    tap.pulse();
    chk(36'({tdo_oe, tdo}), 36'h0);
    tap.state(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test bypass done");
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ops();
    t_dir();
    t_zero();
    t_gate();
    t_bypass();
    conclude();
  end
endmodule
`default_nettype wire
